// File: core/pul_pkg.sv
// package: register map, field positions and reset values of the power-up-late status block
package pul_pkg;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFF_CTRL = 8'h10;
    localparam logic [7:0] OFF_COUNT = 8'h14;
    localparam int FLAG_BIT = 2;
    localparam int CTRL_EVENT_COUNT_ENABLE_BIT = 0;
    localparam int CTRL_DLY_BIT = 1;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] STATUS_MASK = 8'h04;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_POWERUP = 2'b01,
        ST_PREAMBLE = 2'b10
    } tx_state_t;
endpackage

// File: core/tx_powerup_late_status.sv
// module: power-up-late event flag, its event counter and the register slave on AHB-Lite
`timescale 1ns/1ps
`default_nettype none

// Contract
// - flag sits at bit 2 of status byte, only for delayed transmissions
// - on power-up-late keep sending the frame; ranging marker stays on schedule
// - first preamble symbols may be wrong; this never stops the transmission
// - flag is read-only; host writes leave it unchanged, no write-one-clear
// - flag clears when preamble starts and whenever the transmitter returns idle
// - each occurrence bumps the warning counter while event counting is enabled
// - bits 7 to 3 of the status byte are reserved and read zero
module tx_powerup_late_status
    import pul_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic HSEL,
    input wire logic [7:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic TX_START,
    input wire logic POWERUP_DONE,
    input wire logic PREAMBLE_DUE,
    input wire logic RETURN_IDLE,
    output logic TX_ACTIVE,
    output logic RANGING_MARKER,
    input wire logic MARKER_DUE,
    output logic IRQ
);
    import pul_pkg::*;

    // ****************************************
    // bus slave
    // ****************************************
    logic wr_pend_reg;
    logic rd_pend_reg;
    logic [7:0] addr_reg;
    logic [31:0] rdata_next;
    logic tx_powerup_late_flag_reg;
    logic [1:0] ctrl_reg;
    logic [15:0] count_reg;
    logic irq_stat_reg;
    logic irq_mask_reg;
    tx_state_t state_reg;
    logic late_event;
    logic wr_irq_stat;

    wire logic take = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= take && HWRITE;
            rd_pend_reg <= take && !HWRITE;
            if (take) begin
                addr_reg <= HADDR;
            end
        end
    end

    // zero wait states; answer is always OKAY, unmapped reads give zero
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
    end

    always_comb begin
        rdata_next = 32'h0000_0000;
        unique case (HADDR)
            OFF_STATUS: rdata_next[FLAG_BIT] = tx_powerup_late_flag_reg;
            OFF_IRQ_STAT: rdata_next[FLAG_BIT] = irq_stat_reg;
            OFF_IRQ_MASK: rdata_next[FLAG_BIT] = irq_mask_reg;
            OFF_CTRL: rdata_next[1:0] = ctrl_reg;
            OFF_COUNT: rdata_next[15:0] = count_reg;
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // read data is registered at the address phase so it stands in the data phase
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            HRDATA <= 32'h0000_0000;
        end else if (take && !HWRITE) begin
            HRDATA <= rdata_next;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_pend_reg && addr_reg == OFF_CTRL) begin
            ctrl_reg <= HWDATA[1:0];
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            irq_mask_reg <= 1'b0;
        end else if (wr_pend_reg && addr_reg == OFF_IRQ_MASK) begin
            irq_mask_reg <= HWDATA[FLAG_BIT];
        end
    end

    // ****************************************
    // transmit sequence
    // ****************************************
    wire logic delayed_mode = ctrl_reg[CTRL_DLY_BIT];

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= ST_IDLE;
        end else if (RETURN_IDLE) begin
            state_reg <= ST_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE: if (TX_START) begin
                    state_reg <= ST_POWERUP;
                end
                // a late power-up does not abort: preamble starts anyway
                ST_POWERUP: if (PREAMBLE_DUE || POWERUP_DONE && !delayed_mode) begin
                    state_reg <= ST_PREAMBLE;
                end
                ST_PREAMBLE: state_reg <= ST_PREAMBLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // late only if power-up unfinished at the scheduled preamble start
    assign late_event = (state_reg == ST_POWERUP) && PREAMBLE_DUE && !POWERUP_DONE
        && delayed_mode && !RETURN_IDLE;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            TX_ACTIVE <= 1'b0;
        end else begin
            TX_ACTIVE <= !RETURN_IDLE && (state_reg != ST_IDLE || TX_START);
        end
    end

    // marker follows its schedule regardless of the late flag
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            RANGING_MARKER <= 1'b0;
        end else begin
            RANGING_MARKER <= MARKER_DUE && state_reg == ST_PREAMBLE;
        end
    end

    // ****************************************
    // flag, counter and interrupt
    // ****************************************
    // the flag is set in the cycle the preamble begins, so it lives one cycle then
    // clears once the preamble state is seen; software rarely catches it, hence the counter
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            tx_powerup_late_flag_reg <= 1'b0;
        end else if (late_event) begin
            tx_powerup_late_flag_reg <= 1'b1;
        end else if (state_reg == ST_PREAMBLE || state_reg == ST_IDLE || RETURN_IDLE) begin
            tx_powerup_late_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            count_reg <= COUNT_RESET;
        end else if (late_event && ctrl_reg[CTRL_EVENT_COUNT_ENABLE_BIT]) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    assign wr_irq_stat = wr_pend_reg && addr_reg == OFF_IRQ_STAT && HWDATA[FLAG_BIT];

    // set wins over a clear in the same cycle
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            irq_stat_reg <= 1'b0;
        end else if (late_event) begin
            irq_stat_reg <= 1'b1;
        end else if (wr_irq_stat) begin
            irq_stat_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= (irq_stat_reg || late_event) && irq_mask_reg;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    sequence s_late;
        late_event;
    endsequence

    sequence s_flag_then_clear;
        tx_powerup_late_flag_reg ##1 !tx_powerup_late_flag_reg;
    endsequence

    property p_flag_set;
        @(posedge CLK_SYS) disable iff (!RST_N) s_late |=> tx_powerup_late_flag_reg;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set on late event");

    property p_flag_clear;
        @(posedge CLK_SYS) disable iff (!RST_N)
            s_late |=> s_flag_then_clear;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared at preamble");

    property p_idle_clear;
        @(posedge CLK_SYS) disable iff (!RST_N) RETURN_IDLE |=> !tx_powerup_late_flag_reg;
    endproperty
    a_idle_clear: assert property (p_idle_clear) else $error("flag survived idle");

    property p_ro;
        @(posedge CLK_SYS) disable iff (!RST_N)
            wr_pend_reg && addr_reg == OFF_STATUS && !late_event && state_reg == ST_POWERUP
            |=> tx_powerup_late_flag_reg == $past(tx_powerup_late_flag_reg);
    endproperty
    a_ro: assert property (p_ro) else $error("host write changed flag");

    property p_count;
        @(posedge CLK_SYS) disable iff (!RST_N)
            (s_late and ctrl_reg[CTRL_EVENT_COUNT_ENABLE_BIT]) |=> count_reg == $past(count_reg) + 16'h0001;
    endproperty
    a_count: assert property (p_count) else $error("counter missed event");

    property p_count_hold;
        @(posedge CLK_SYS) disable iff (!RST_N)
            !ctrl_reg[CTRL_EVENT_COUNT_ENABLE_BIT] |=> $stable(count_reg);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("counter moved while off");

    property p_continue;
        @(posedge CLK_SYS) disable iff (!RST_N) s_late |=> state_reg == ST_PREAMBLE;
    endproperty
    a_continue: assert property (p_continue) else $error("late event aborted frame");

    property p_reserved;
        @(posedge CLK_SYS) disable iff (!RST_N)
            take && !HWRITE && HADDR == OFF_STATUS |=> (HRDATA & ~32'h0000_0004) == 32'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved status bits nonzero");

    property p_delayed_only;
        @(posedge CLK_SYS) disable iff (!RST_N) !delayed_mode |-> !late_event;
    endproperty
    a_delayed_only: assert property (p_delayed_only) else $error("flag outside delayed tx");

    // only the late condition may raise the flag, so a host write can never fake one
    property p_rise_cause;
        @(posedge CLK_SYS) disable iff (!RST_N)
            $rose(tx_powerup_late_flag_reg) |-> $past(late_event);
    endproperty
    a_rise_cause: assert property (p_rise_cause) else $error("flag rose without event");

    property p_idle_low;
        @(posedge CLK_SYS) disable iff (!RST_N)
            state_reg == ST_IDLE |-> !tx_powerup_late_flag_reg;
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("flag set while idle");

    property p_marker;
        @(posedge CLK_SYS) disable iff (!RST_N)
            MARKER_DUE && state_reg == ST_PREAMBLE |=> RANGING_MARKER;
    endproperty
    a_marker: assert property (p_marker) else $error("ranging marker dropped");

    sequence s_sending;
        state_reg == ST_PREAMBLE && !RETURN_IDLE;
    endsequence

    property p_keep_sending;
        @(posedge CLK_SYS) disable iff (!RST_N)
            s_sending |=> state_reg == ST_PREAMBLE;
    endproperty
    a_keep_sending: assert property (p_keep_sending) else $error("frame stopped early");

    property p_irq_on;
        @(posedge CLK_SYS) disable iff (!RST_N)
            irq_stat_reg && irq_mask_reg |=> IRQ;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("interrupt missing");

    property p_irq_off;
        @(posedge CLK_SYS) disable iff (!RST_N)
            !irq_stat_reg && !late_event |=> !IRQ;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt without event");

    property p_w1c;
        @(posedge CLK_SYS) disable iff (!RST_N)
            wr_irq_stat && !late_event |=> !irq_stat_reg;
    endproperty
    a_w1c: assert property (p_w1c) else $error("event status not cleared");
endmodule

`default_nettype wire

// File: verif/tx_powerup_late_status_test.sv
// testbench: power-up-late flag, warning counter and interrupt against an integer model
`timescale 1ns/1ps
`default_nettype none
module tx_powerup_late_status_test;
    import pul_pkg::*;
    logic clk_sys, rst_n, hsel, hwrite, hready, hreadyout, hresp, tx_start, powerup_done;
    logic preamble_due, return_idle, marker_due, tx_active, ranging_marker, irq;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd;
    int failures, samples_checked, cnt, stat, mask, ctrl, late;
    assign hready = hreadyout;
    tx_powerup_late_status tx_powerup_late_status_inst (.CLK_SYS(clk_sys), .RST_N(rst_n),
        .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
        .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hreadyout),
        .HRESP(hresp), .TX_START(tx_start), .POWERUP_DONE(powerup_done),
        .PREAMBLE_DUE(preamble_due), .RETURN_IDLE(return_idle), .TX_ACTIVE(tx_active),
        .RANGING_MARKER(ranging_marker), .MARKER_DUE(marker_due), .IRQ(irq));
    // ****************************************
    // bus and comparison tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // waits are open ended here; the watchdog cuts a stuck slave short
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge clk_sys);
        while (hready !== 1'b1) @(posedge clk_sys);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk_sys);
        while (hready !== 1'b1) @(posedge clk_sys);
        rd = hrdata;
    endtask
    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        check(what, rd, exp);
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask
    // one delayed or immediate frame; late_pick withholds power-up at the preamble instant
    task automatic frame(input int late_pick);
        @(posedge clk_sys);
        tx_start <= 1'b1;
        powerup_done <= 1'b0;
        @(posedge clk_sys);
        tx_start <= 1'b0;
        // a host write during power-up must leave the flag alone
        ahb(1'b1, OFF_STATUS, 32'hFFFFFFFF);
        repeat ($urandom_range(0, 3)) @(posedge clk_sys);
        powerup_done <= (late_pick == 0);
        preamble_due <= 1'b1;
        if (ctrl[1] && late_pick != 0) begin
            stat = 1;
            if (ctrl[0]) cnt++;
        end
        // the read address phase lands in the single cycle in which the flag stands
        fork
            rchk("status live", OFF_STATUS, stat != 0 ? 32'h4 : 32'h0);
            begin
                @(posedge clk_sys);
                preamble_due <= 1'b0;
                powerup_done <= 1'b1;
            end
        join
        marker_due <= 1'b1;
        @(posedge clk_sys);
        marker_due <= 1'b0;
        #1;
        check("marker", {31'h0, ranging_marker}, 32'h1);
        check("active", {31'h0, tx_active}, 32'h1);
        @(posedge clk_sys);
        return_idle <= 1'b1;
        @(posedge clk_sys);
        return_idle <= 1'b0;
        @(posedge clk_sys);
        #1;
        check("idle", {31'h0, tx_active}, 32'h0);
        check("irq", {31'h0, irq}, {31'h0, stat != 0 && mask != 0});
        rchk("count", OFF_COUNT, cnt & 32'hFFFF);
        rchk("status", OFF_STATUS, 32'h0);
        rchk("irq status", OFF_IRQ_STAT, stat != 0 ? 32'h4 : 32'h0);
        ahb(1'b1, OFF_IRQ_STAT, 32'h4);
        stat = 0;
        rchk("irq cleared", OFF_IRQ_STAT, 32'h0);
        #1;
        check("irq off", {31'h0, irq}, 32'h0);
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        finish_test;
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {rst_n, hsel, hwrite, tx_start, powerup_done, preamble_due} = 6'h00;
        {return_idle, marker_due, haddr, htrans, hwdata} = 44'h0;
        hsize = 3'h2;
        {failures, samples_checked, cnt, stat, mask, ctrl} = 192'h0;
        void'($urandom(64));
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        rchk("status rst", OFF_STATUS, 32'h0);
        rchk("mask rst", OFF_IRQ_MASK, 32'h0);
        rchk("ctrl rst", OFF_CTRL, 32'h0);
        rchk("count rst", OFF_COUNT, 32'h0);
        ahb(1'b1, OFF_STATUS, 32'hFFFFFFFF);
        rchk("status ro", OFF_STATUS, 32'h0);
        ahb(1'b1, 8'h20, 32'hFFFFFFFF);
        rchk("unmapped", 8'h20, 32'h0);
        for (int i = 0; i < 24; i++) begin
            ctrl = (i < 8) ? i % 4 : $urandom_range(0, 3);
            late = (i < 8) ? i / 4 : $urandom_range(0, 1);
            mask = $urandom_range(0, 1);
            ahb(1'b1, OFF_CTRL, ctrl);
            ahb(1'b1, OFF_IRQ_MASK, mask != 0 ? 32'h4 : 32'h0);
            rchk("ctrl", OFF_CTRL, ctrl);
            frame(late);
        end
        finish_test;
    end
endmodule
`default_nettype wire
